// *** hdl/adc_port_defines.svh ***
// Constants for the converter serial command port and its register bus.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// ------------------------------------------------------------------
// Register byte offsets on the bus
// ------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MASK        8'h08
`define REG_CMD         8'h0C
`define REG_TXDATA      8'h10
`define REG_STATE       8'h14

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define CTRL_LINE50_BIT 0
`define CTRL_START_BIT  1
`define EVT_CMD_BIT     0
`define EVT_DONE_BIT    1
`define EVT_FRAME_BIT   2
`define EVT_WIDTH       3
`define EVT_RESET       3'h0
`define BYTE_RESET      8'h00
`define USER_RESET      4'h0
`define WORD_ZERO       32'h0000_0000

// ------------------------------------------------------------------
// Serial command byte layout: opcode in the top two bits
// ------------------------------------------------------------------
`define OP_USER         2'h1
`define OP_SELECT       2'h2
`define OP_CONVERT      2'h3
`define BITS_PER_BYTE   4'h8
`define MSB_POSITION    7

// ------------------------------------------------------------------
// Integration period in converter clock periods
// ------------------------------------------------------------------
`define INTEG_50HZ      10'd655
`define INTEG_60HZ      10'd545

`endif

// *** hdl/adc_port_pkg.sv ***
// Types shared by the converter serial port and its conversion timer.
// Assumes the defines header supplies all numeric constants.
package adc_port_pkg;

    // Conversion timer states, Gray along idle, integrate, done
    typedef enum logic [1:0] {
        CONV_IDLE  = 2'b00,
        CONV_INTEG = 2'b01,
        CONV_DONE  = 2'b11
    } conv_state_t;

    // Readback source chosen for the next frame
    typedef enum logic [1:0] {
        SRC_STATE  = 2'b00,
        SRC_CMD    = 2'b01,
        SRC_TXDATA = 2'b10,
        SRC_FRAMES = 2'b11
    } rb_src_t;

endpackage

// *** hdl/adc_conv_timer.sv ***
// Conversion timer: counts converter clock periods of the integration phase.
// Assumes osc_in is an asynchronous pin; start is a one-cycle pulse on clk.
`timescale 1ns/1ps
`include "adc_port_defines.svh"
module adc_conv_timer
    import adc_port_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       osc_in,
    input  wire logic       start,
    input  wire logic       mode_50hz,
    output logic            busy,
    output logic            done
);

    logic        osc_s1_r;
    logic        osc_s2_r;
    logic        osc_d_r;
    logic [9:0]  cnt_r;
    logic [9:0]  limit_r;
    conv_state_t state_r;
    conv_state_t state_nxt;
    wire         osc_rise = osc_s2_r & ~osc_d_r;
    wire         at_limit = (cnt_r == limit_r);

    // ------------------------------------------------------------------
    // Oscillator pin synchroniser and edge detect
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_d_r  <= 1'b0;
        end else begin
            osc_s1_r <= osc_in;
            osc_s2_r <= osc_s1_r;
            osc_d_r  <= osc_s2_r;
        end
    end

    // Next state; a restart while busy begins a fresh period; the final counted edge beats it in the same cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CONV_IDLE:  if (start) state_nxt = CONV_INTEG;
            CONV_INTEG: if (osc_rise && at_limit) state_nxt = CONV_DONE;
            CONV_DONE:  state_nxt = start ? CONV_INTEG : CONV_IDLE;
            default:    state_nxt = CONV_IDLE;
        endcase
    end

    // Period length latched at start so a mode change mid-way is harmless
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= CONV_IDLE;
            cnt_r   <= 10'd0;
            limit_r <= `INTEG_60HZ;
        end else begin
            state_r <= state_nxt;
            if (start) begin
                cnt_r   <= 10'd1;
                limit_r <= mode_50hz ? `INTEG_50HZ : `INTEG_60HZ;
            end else if (state_r == CONV_INTEG && osc_rise) begin
                cnt_r <= cnt_r + 10'd1;
            end
        end
    end

    assign busy = (state_r == CONV_INTEG);
    assign done = (state_r == CONV_DONE);

endmodule

// *** hdl/adc_serial_command_port.sv ***
// Serial command and readback port of an integrating converter, with an
// AHB-Lite register slave, sticky interrupt status and a conversion timer.
// Assumes REF_CLK at 25 MHz; CS_N, SCLK, DIN and OSC_INPUT are asynchronous
// pins, SCLK at least 8 REF_CLK periods long and idle low between bytes.
`timescale 1ns/1ps
`include "adc_port_defines.svh"
module adc_serial_command_port
    import adc_port_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    // Serial link pins
    input  wire logic        CS_N,
    input  wire logic        SCLK,
    input  wire logic        DIN,
    output logic             DOUT_O,
    output logic             DOUT_OE,
    // Converter clock pin
    input  wire logic        OSC_INPUT,
    // Host-programmed outputs and conversion flag
    output logic             USER_OUT_BIT0,
    output logic             USER_OUT_BIT1,
    output logic             USER_OUT_BIT2,
    output logic             USER_OUT_BIT3,
    output logic             CONV_DONE,
    output logic             IRQ,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                   cs_s1_r;
    logic                   cs_s2_r;
    logic                   cs_d_r;
    logic                   sclk_s1_r;
    logic                   sclk_s2_r;
    logic                   sclk_d_r;
    logic                   din_s1_r;
    logic                   din_s2_r;
    logic [7:0]             in_shift_r;
    logic [3:0]             bit_cnt_r;
    logic [7:0]             out_shift_r;
    logic                   dout_r;
    logic                   dout_oe_r;
    logic [7:0]             cmd_r;
    logic [7:0]             frames_r;
    rb_src_t                src_r;
    logic [3:0]             user_r;
    logic                   line50_r;
    logic                   start_r;
    logic                   conv_done_r;
    logic [7:0]             txdata_r;
    logic [`EVT_WIDTH-1:0]  status_r;
    logic [`EVT_WIDTH-1:0]  mask_r;
    logic                   irq_r;
    logic                   wr_pend_r;
    logic [7:0]             wr_addr_r;
    logic [31:0]            hrdata_r;
    logic                   conv_busy;
    logic                   conv_done_lvl;
    logic                   conv_done_d_r;
    logic                   hready_r;
    logic                   hresp_r;

    // Rising or falling edge of a synchronised level and its delayed copy
    function automatic logic edge_of(input logic now, input logic was, input logic rise);
        edge_of = rise ? (now & ~was) : (~now & was);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers; first stages feed only the second stages
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_d_r    <= 1'b1;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r  <= 1'b0;
            din_s1_r  <= 1'b0;
            din_s2_r  <= 1'b0;
        end else begin
            cs_s1_r   <= CS_N;
            cs_s2_r   <= cs_s1_r;
            cs_d_r    <= cs_s2_r;
            sclk_s1_r <= SCLK;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r  <= sclk_s2_r;
            din_s1_r  <= DIN;
            din_s2_r  <= din_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Frame events
    // ------------------------------------------------------------------
    // DIN rides the same two-stage delay as SCLK, so setup and hold carry over
    wire selected   = ~cs_s2_r & ~cs_d_r;
    wire cs_fall    = edge_of(cs_s2_r, cs_d_r, 1'b0);
    wire cs_rise    = edge_of(cs_s2_r, cs_d_r, 1'b1);
    wire sclk_rise  = selected & edge_of(sclk_s2_r, sclk_d_r, 1'b1);
    wire sclk_fall  = selected & edge_of(sclk_s2_r, sclk_d_r, 1'b0);
    wire full_byte  = (bit_cnt_r == `BITS_PER_BYTE);
    wire commit     = cs_rise & full_byte;
    wire [1:0] op   = in_shift_r[7:6];
    wire op_user    = commit & (op == `OP_USER);
    wire op_select  = commit & (op == `OP_SELECT);
    wire op_convert = commit & (op == `OP_CONVERT);

    // ------------------------------------------------------------------
    // Input shifter: MSB enters first and ends in the top bit
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            in_shift_r <= `BYTE_RESET;
            bit_cnt_r  <= 4'h0;
        end else if (cs_fall) begin
            bit_cnt_r  <= 4'h0;
        end else if (sclk_rise) begin
            in_shift_r <= {in_shift_r[6:0], din_s2_r};
            bit_cnt_r  <= full_byte ? bit_cnt_r : bit_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Command commit on select release
    // ------------------------------------------------------------------
    // A short frame commits nothing; a long one keeps its last eight bits
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            cmd_r    <= `BYTE_RESET;
            frames_r <= `BYTE_RESET;
            src_r    <= SRC_STATE;
            user_r   <= `USER_RESET;
        end else if (commit) begin
            cmd_r    <= in_shift_r;
            frames_r <= frames_r + 8'h01;
            if (op_user)
                user_r <= in_shift_r[3:0];
            if (op_select)
                src_r  <= rb_src_t'(in_shift_r[1:0]);
        end
    end

    // ------------------------------------------------------------------
    // Readback selection for the next frame
    // ------------------------------------------------------------------
    wire [7:0] state_byte = {conv_busy, conv_done_r, line50_r, 1'b0, user_r};
    wire [7:0] rb_byte    = (src_r == SRC_STATE)  ? state_byte :
                            (src_r == SRC_CMD)    ? cmd_r      :
                            (src_r == SRC_TXDATA) ? txdata_r   : frames_r;

    // ------------------------------------------------------------------
    // Output shifter and data pin driver
    // ------------------------------------------------------------------
    // The first bit is on the pin as soon as the frame opens
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            out_shift_r <= `BYTE_RESET;
            dout_r      <= 1'b0;
        end else if (cs_fall) begin
            out_shift_r <= rb_byte;
            dout_r      <= rb_byte[`MSB_POSITION];
        end else if (sclk_fall) begin
            out_shift_r <= {out_shift_r[6:0], 1'b0};
            dout_r      <= out_shift_r[`MSB_POSITION-1];
        end
    end

    // Enable follows the synchronised select, released one cycle after it rises
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET)
            dout_oe_r <= 1'b0;
        else
            dout_oe_r <= ~cs_s2_r;
    end

    // ------------------------------------------------------------------
    // AHB-Lite address and data phase
    // ------------------------------------------------------------------
    wire       addr_ok  = HSEL & HTRANS[1] & HREADY;
    wire       rd_take  = addr_ok & ~HWRITE;
    wire       wr_take  = addr_ok & HWRITE;
    wire [7:0] rd_addr  = HADDR[7:0];
    wire       rd_stat  = rd_take & (rd_addr == `REG_STATUS);
    wire       wr_ctrl  = wr_pend_r & (wr_addr_r == `REG_CTRL);
    wire       wr_mask  = wr_pend_r & (wr_addr_r == `REG_MASK);
    wire       wr_tx    = wr_pend_r & (wr_addr_r == `REG_TXDATA);
    wire       sw_start = wr_ctrl & HWDATA[`CTRL_START_BIT];

    // Read data for the address phase; unmapped offsets read as zero
    wire [31:0] rd_mux =
        (rd_addr == `REG_CTRL)   ? {31'h0, line50_r} :
        (rd_addr == `REG_STATUS) ? {29'h0, status_r} :
        (rd_addr == `REG_MASK)   ? {29'h0, mask_r} :
        (rd_addr == `REG_CMD)    ? {24'h0, cmd_r} :
        (rd_addr == `REG_TXDATA) ? {24'h0, txdata_r} :
        (rd_addr == `REG_STATE)  ? {24'h0, state_byte} : `WORD_ZERO;

    // Zero wait states: read data is registered at the address-phase edge
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= `WORD_ZERO;
        end else begin
            wr_pend_r <= wr_take;
            wr_addr_r <= wr_take ? HADDR[7:0] : wr_addr_r;
            hrdata_r  <= rd_take ? rd_mux : hrdata_r;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // A convert command also sets the line bit so both paths agree
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            line50_r <= 1'b0;
            mask_r   <= `EVT_RESET;
            txdata_r <= `BYTE_RESET;
        end else begin
            if (op_convert)
                line50_r <= in_shift_r[0];
            else if (wr_ctrl)
                line50_r <= HWDATA[`CTRL_LINE50_BIT];
            if (wr_mask)
                mask_r   <= HWDATA[`EVT_WIDTH-1:0];
            if (wr_tx)
                txdata_r <= HWDATA[7:0];
        end
    end

    // Start pulse lands with the updated line bit
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET)
            start_r <= 1'b0;
        else
            start_r <= op_convert | sw_start;
    end

    // ------------------------------------------------------------------
    // Conversion timer
    // ------------------------------------------------------------------
    adc_conv_timer u_timer (
        .clk       (REF_CLK),
        .rst       (RESET),
        .osc_in    (OSC_INPUT),
        .start     (start_r),
        .mode_50hz (line50_r),
        .busy      (conv_busy),
        .done      (conv_done_lvl)
    );

    wire conv_finished = conv_done_lvl & ~conv_done_d_r;

    // Done flag stays up until a start clears it; completion beats a start in the same cycle
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            conv_done_d_r <= 1'b0;
            conv_done_r   <= 1'b0;
        end else begin
            conv_done_d_r <= conv_done_lvl;
            if (conv_finished)
                conv_done_r <= 1'b1;
            else if (start_r)
                conv_done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, read to clear; a new event beats the clear
    // ------------------------------------------------------------------
    wire [`EVT_WIDTH-1:0] events;
    assign events[`EVT_CMD_BIT]   = commit;
    assign events[`EVT_DONE_BIT]  = conv_finished;
    assign events[`EVT_FRAME_BIT] = cs_fall;

    wire [`EVT_WIDTH-1:0] status_nxt = (rd_stat ? `EVT_RESET : status_r) | events;

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            status_r <= `EVT_RESET;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & mask_r);
        end
    end

    // Bus answer from flops; this slave never stalls and never errors
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            hready_r <= 1'b1;
            hresp_r  <= 1'b0;
        end else begin
            hready_r <= 1'b1;
            hresp_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Output assignments, all from flip-flops
    // ------------------------------------------------------------------
    assign DOUT_O        = dout_r;
    assign DOUT_OE       = dout_oe_r;
    assign USER_OUT_BIT0 = user_r[0];
    assign USER_OUT_BIT1 = user_r[1];
    assign USER_OUT_BIT2 = user_r[2];
    assign USER_OUT_BIT3 = user_r[3];
    assign CONV_DONE     = conv_done_r;
    assign IRQ           = irq_r;
    assign HRDATA        = hrdata_r;
    assign HREADYOUT     = hready_r;
    assign HRESP         = hresp_r;

endmodule

// *** sim/adc_port_props.sv ***
// Port checker for the converter serial command port.
// Assumes REF_CLK as the only sampling clock and RESET async high.
`timescale 1ns/1ps
module adc_port_props
(
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        CS_N,
    input wire logic        SCLK,
    input wire logic        OSC_INPUT,
    input wire logic        DOUT_O,
    input wire logic        DOUT_OE,
    input wire logic        USER_OUT_BIT0,
    input wire logic        USER_OUT_BIT1,
    input wire logic        USER_OUT_BIT2,
    input wire logic        USER_OUT_BIT3,
    input wire logic        CONV_DONE,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP
);
    logic [3:0] csr_age_r;
    logic [3:0] skf_age_r;
    logic [3:0] osc_age_r;
    wire  [3:0] users = {USER_OUT_BIT3, USER_OUT_BIT2, USER_OUT_BIT1, USER_OUT_BIT0};
    wire        rd_take = HSEL && HTRANS[1] && !HWRITE && HREADY;

    // ------------------------------------------------------------
    // Saturating ages of pin edges; pins are raw, so allow sync lag
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            csr_age_r <= 4'hF;
            skf_age_r <= 4'hF;
            osc_age_r <= 4'hF;
        end else begin
            csr_age_r <= $rose(CS_N) ? 4'h0 : csr_age_r + {3'h0, csr_age_r != 4'hF};
            skf_age_r <= $fell(SCLK) ? 4'h0 : skf_age_r + {3'h0, skf_age_r != 4'hF};
            osc_age_r <= $rose(OSC_INPUT) ? 4'h0 : osc_age_r + {3'h0, osc_age_r != 4'hF};
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    oe_open_a: assert property ($fell(CS_N) |-> ##[1:5] DOUT_OE)
        else $error("output not driven after select fell");
    oe_hold_a: assert property (!CS_N [*6] |-> DOUT_OE)
        else $error("output released inside a frame");
    oe_close_a: assert property ($rose(CS_N) |-> ##[1:5] !DOUT_OE)
        else $error("output still driven after select rose");
    oe_idle_a: assert property (CS_N [*6] |-> !DOUT_OE)
        else $error("output driven while deselected");
    user_commit_a: assert property (!$stable(users) |-> csr_age_r <= 4'h6)
        else $error("user outputs moved away from a commit");
    dout_shift_a: assert property (!$stable(DOUT_O) && DOUT_OE && $past(DOUT_OE)
        |-> skf_age_r <= 4'h6)
        else $error("data output moved without a clock fall");
    done_edge_a: assert property ($rose(CONV_DONE) |-> osc_age_r <= 4'h6)
        else $error("done rose away from a converter clock edge");
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus slave stalled or errored");
    rdata_hold_a: assert property (!$stable(HRDATA) |-> $past(rd_take))
        else $error("read data changed without a read");

    cover property ($rose(CONV_DONE));
    cover property ($rose(USER_OUT_BIT3));
    cover property ($fell(CS_N) ##[1:5] DOUT_OE);
endmodule

bind adc_serial_command_port adc_port_props chk (.REF_CLK, .RESET, .CS_N, .SCLK,
    .OSC_INPUT, .DOUT_O, .DOUT_OE, .USER_OUT_BIT0, .USER_OUT_BIT1, .USER_OUT_BIT2,
    .USER_OUT_BIT3, .CONV_DONE, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA,
    .HREADYOUT, .HRESP);

// *** sim/host_serial_model.sv ***
// Host side of the serial link: frames of up to 8 bits, MSB first.
// Assumes clk is the 25 MHz bench clock; half a link period is 4 cycles.
`timescale 1ns/1ps
module host_serial_model
(
    input  wire logic clk,
    input  wire logic dout_o,
    input  wire logic dout_oe,
    output logic      cs_n,
    output logic      sclk,
    output logic      din
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // One frame; link clock stands still outside it
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        cs_n <= 1'b0;
        repeat (4) half();
        for (int i = 7; i > 7 - nbits; i--) begin
            din <= tx[i];
            half();
            sclk <= 1'b1;
            rx[i] = dout_oe ? dout_o : 1'bx;
            half();
            sclk <= 1'b0;
        end
        repeat (3) half();
        cs_n <= 1'b1;
        din <= ~din; // Released line shows no stale level
        repeat (7) half();
    endtask

    // Clock pulses with select high, must leave everything alone
    task automatic stray();
        repeat (3) begin
            sclk <= 1'b1;
            din <= ~din;
            half();
            sclk <= 1'b0;
            half();
        end
    endtask
endmodule

// *** sim/adc_serial_command_port_tb.sv ***
// Self-checking bench: AHB-Lite master tasks plus the serial host model.
// Assumes the defines header and package compile ahead of this file.
`timescale 1ns/1ps
`include "adc_port_defines.svh"
module adc_serial_command_port_tb;
    import adc_port_pkg::*;
    logic        ref_clk, reset, cs_n, sclk, din, dout_o, dout_oe, osc;
    logic        u0, u1, u2, u3, conv_done, irq, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [7:0]  rx;
    logic [2:0]  osc_div;
    int          osc_edges, mark, failures, n_compared;
    wire  [3:0]  users = {u3, u2, u1, u0};

    adc_serial_command_port dut (.REF_CLK(ref_clk), .RESET(reset), .CS_N(cs_n),
        .SCLK(sclk), .DIN(din), .DOUT_O(dout_o), .DOUT_OE(dout_oe), .OSC_INPUT(osc),
        .USER_OUT_BIT0(u0), .USER_OUT_BIT1(u1), .USER_OUT_BIT2(u2), .USER_OUT_BIT3(u3),
        .CONV_DONE(conv_done), .IRQ(irq), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));
    host_serial_model host (.clk(ref_clk), .dout_o(dout_o), .dout_oe(dout_oe),
        .cs_n(cs_n), .sclk(sclk), .din(din));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Converter clock, 12 bench cycles a period, counted as it rises
    always @(posedge ref_clk) begin
        osc_div <= (osc_div == 3'h5) ? 3'h0 : osc_div + 3'h1;
        if (osc_div == 3'h5) begin
            osc <= ~osc;
            osc_edges <= osc_edges + (osc ? 0 : 1);
        end
    end
    always @(posedge cs_n) mark = osc_edges;

    // ------------------------------------------------------------
    // Checking, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t ns: %s", $time, what);
            failures++;
        end
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            $display("unexpected at %0t ns: bus timeout", $time);
            failures++;
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    // Waits for done and checks the converter clock count since the start
    task automatic conv_check(input int n);
        int k;
        k = 0;
        while (conv_done !== 1'b1 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
        if (conv_done !== 1'b1) begin
            $display("unexpected at %0t ns: conversion timeout", $time);
            failures++;
            wrap_up();
        end
        check(32'(osc_edges - mark >= n && osc_edges - mark <= n + 1), 32'h1, "span");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {reset, osc, osc_div, osc_edges, mark, failures, n_compared} = '1;
        {osc, osc_div, osc_edges, mark, failures, n_compared} = '0;
        {hsel, htrans, hwrite, haddr, hwdata} = '0;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check(32'(dout_oe), 32'h0, "enable at rest");
        check(32'(users), 32'h0, "user reset");
        bus(1'b1, `REG_MASK, 32'h7);
        bus(1'b1, `REG_TXDATA, 32'hA5);
        host.xfer(8'h82, 8, rx);
        host.xfer(8'h4A, 8, rx);
        check(32'(rx), 32'hA5, "readback of tx byte");
        check(32'(users), 32'hA, "user pattern");
        check(32'(irq), 32'h1, "irq raised");
        bus(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h5, "status bits");
        bus(1'b0, `REG_CMD, 32'h0);
        check(rd, 32'h4A, "committed byte");
        repeat (3) @(posedge ref_clk);
        check(32'(irq), 32'h0, "irq cleared");
        for (int i = 0; i < 4; i++) begin
            host.xfer(8'h40 | (8'h1 << i), 8, rx);
            check(32'(users), 32'h1 << i, "walking user bit");
        end
        host.xfer(8'h81, 8, rx);
        host.xfer(8'h00, 8, rx);
        check(32'(rx), 32'h81, "readback of command");
        host.xfer(8'h4F, 5, rx);
        host.stray();
        bus(1'b0, `REG_CMD, 32'h0);
        check(rd, 32'h0, "short frame and stray clocks");
        check(32'(users), 32'h8, "users kept");
        host.xfer(8'hC1, 8, rx);
        conv_check(655);
        bus(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h7, "done status");
        bus(1'b1, `REG_MASK, 32'h0);
        mark = osc_edges;
        bus(1'b1, `REG_CTRL, 32'h2);
        repeat (2) @(posedge ref_clk);
        check(32'(conv_done), 32'h0, "done cleared by start");
        conv_check(545);
        check(32'(irq), 32'h0, "masked irq");
        bus(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h2, "done only");
        bus(1'b0, 8'h1C, 32'h0);
        check(rd, 32'h0, "unmapped read");
        bus(1'b0, `REG_TXDATA, 32'h0);
        check(rd, 32'hA5, "tx byte kept");
        wrap_up();
    end
endmodule
